/* File: hdl/adc_control.sv */
// Converter control, register file, sequencing and result presentation
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
// Contract
// RULE1: After completion with done flag high, result registers hold the conversion code.
// RULE2: Single-ended code is input times 1024 over reference, 0x000 to 0x3FF.
// RULE3: Differential code is difference times 512 over reference, clamped 0x1FF and 0x200.
// RULE4: Reference field: 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V.
// RULE5: Reference and channel writes during a conversion apply after it completes.
// RULE6: Alignment bit picks left or right presentation, effective at once.
// RULE7: Channel codes 0-7 select single inputs; 11110 bandgap; 11111 ground.
// RULE8: 10000-10111 pair inputs with input 1; 11000-11101 with input 2; 01xxx unused.
// RULE9: Enable powers the converter; clearing it aborts a running conversion.
// RULE10: Single mode starts exactly one conversion per start write.
// RULE11: Free-running mode needs one start write, then converts continuously.
// RULE12: First conversion after enabling takes 25 conversion clocks, others 13.
// RULE13: Start bit reads one while converting, zero after; writing zero does nothing.
// RULE14: Done flag sets on completion; cleared by vector acknowledge or writing one.
// RULE15: Prescaler divides system clock by 2,2,4,...,128 to make the conversion clock.
// RULE16: After low byte read, results freeze until the high byte is read.
// RULE17: Right: high bits 9:8 in 1:0, low 7:0; left: high 9:2, low 1:0 in 7:6.
// RULE18: Interrupt request is high while done flag and interrupt enable are set.
// RULE19: With auto-trigger enabled, each rising trigger input edge starts a conversion.
module adc_control (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire adc_ctrl_pkg::reg_req_t   bus_req,
	output logic      [7:0]               rdata,
	input  wire logic [9:0]               analog_input_n [8],
	input  wire logic [9:0]               bandgap_voltage,
	input  wire logic                     trigger_in,
	input  wire logic                     irq_ack,
	output logic                          irq,
	output logic                          done_irq_req,
	output logic                          converter_power,
	output adc_ctrl_pkg::mux_route_t      route
);
	import adc_ctrl_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b10
	} conv_state_t;

	conv_state_t   state;
	logic [7:0]    ctrl_a;
	logic [7:0]    mux_sel;
	conv_setting_t active;
	logic [4:0]    cycle_count;
	logic [4:0]    cycle_target;
	logic          first_pending;
	logic          conv_done_flag;
	logic [9:0]    result;
	logic          result_locked;
	logic [7:0]    irq_status;
	logic [7:0]    irq_mask;
	logic          trig_prev;
	logic          conv_tick;
	logic [9:0]    coded;
	logic [9:0]    pos_sample;
	logic [9:0]    neg_sample;
	logic [7:0]    result_low_byte;
	logic [7:0]    result_high_byte;
	logic          wr_ctrl;
	logic          start_req;
	logic          finish;
	logic          converting;
	logic          enable_now;
	mux_route_t    next_route;

	assign wr_ctrl    = bus_req.wr && bus_req.addr == OFF_CTRL_A;
	assign converting = state == ST_CONV;
	assign enable_now = wr_ctrl ? bus_req.wdata[BIT_ENABLE] : ctrl_a[BIT_ENABLE];
	assign finish     = converting && conv_tick && cycle_count == cycle_target - 5'd1;

	always_comb begin
		start_req = 1'b0;
		if (wr_ctrl && bus_req.wdata[BIT_START])
			start_req = 1'b1; // Writing zero is ignored [RULE10] [RULE13]
		if (ctrl_a[BIT_AUTO_TRIG] && trigger_in && !trig_prev)
			start_req = 1'b1; // [RULE19]
		if (ctrl_a[BIT_AUTO_TRIG] && finish)
			start_req = 1'b1; // Free running restart [RULE11]
		if (!enable_now)
			start_req = 1'b0;
	end

	always_comb begin
		next_route = '0;
		next_route.ext_ref_on      = active.ref_sel == REF_EXTERNAL; // [RULE4]
		next_route.supply_ref_on   = active.ref_sel == REF_SUPPLY; // [RULE4]
		next_route.internal_ref_on = active.ref_sel == REF_INTERNAL; // [RULE4]
		next_route.channel_valid   = 1'b1;
		if (active.channel[4:3] == 2'b00) begin
			next_route.pos_input = active.channel[2:0]; // [RULE7]
		end else if (active.channel == CH_BANDGAP) begin
			next_route.use_bandgap = 1'b1; // [RULE7]
		end else if (active.channel == CH_GROUND) begin
			next_route.use_ground = 1'b1; // [RULE7]
		end else if (active.channel[4:3] == 2'b10) begin
			next_route.differential = 1'b1; // [RULE8]
			next_route.pos_input    = active.channel[2:0];
			next_route.neg_input    = 3'h1;
		end else if (active.channel[4:3] == 2'b11) begin
			next_route.differential = 1'b1; // [RULE8]
			next_route.pos_input    = active.channel[2:0];
			next_route.neg_input    = 3'h2;
		end else begin
			next_route.channel_valid = 1'b0; // Unused 01xxx codes [RULE8]
		end
		// Reserved reference leaves every reference off and the channel invalid
		if (active.ref_sel == REF_RESERVED)
			next_route.channel_valid = 1'b0;
	end

	always_comb begin
		if (next_route.use_bandgap)
			pos_sample = bandgap_voltage;
		else if (next_route.use_ground)
			pos_sample = 10'h000;
		else
			pos_sample = analog_input_n[next_route.pos_input];
		neg_sample = analog_input_n[next_route.neg_input];
	end

	adc_result_coder u_coder (
		.differential (next_route.differential),
		.pos_sample   (pos_sample),
		.neg_sample   (neg_sample),
		.code         (coded)
	);

	adc_clock_divider u_div (
		.mclk                 (mclk),
		.rst                  (rst),
		.run                  (converting),
		.clock_divider_select (ctrl_a[2:0]),
		.conv_tick            (conv_tick)
	);

	// Trigger history resets to the idle low level so reset gives no false edge
	always_ff @(posedge mclk) begin
		if (rst)
			trig_prev <= 1'b0;
		else
			trig_prev <= trigger_in; // [RULE19]
	end

	// Control register A, start bit tracks the busy state
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_a <= CTRL_A_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_a[BIT_ENABLE]    <= bus_req.wdata[BIT_ENABLE];
				ctrl_a[BIT_AUTO_TRIG] <= bus_req.wdata[BIT_AUTO_TRIG];
				ctrl_a[BIT_DONE_IE]   <= bus_req.wdata[BIT_DONE_IE];
				ctrl_a[2:0]           <= bus_req.wdata[2:0];
			end
			ctrl_a[BIT_START]     <= start_req || (converting && !finish && enable_now); // [RULE13]
			ctrl_a[BIT_DONE_FLAG] <= 1'b0;
		end
	end

	// Mux select register; live fields shadowed into the active setting
	always_ff @(posedge mclk) begin
		if (rst) begin
			mux_sel <= MUX_SEL_RESET;
			active  <= '0;
		end else begin
			if (bus_req.wr && bus_req.addr == OFF_MUX_SEL)
				mux_sel <= bus_req.wdata;
			// Held off during a conversion; a free-running restart takes the new setting [RULE5]
			if (!converting || finish)
				active <= '{ref_sel: mux_sel[7:6], channel: mux_sel[4:0]};
		end
	end

	// Conversion sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state         <= ST_IDLE;
			cycle_count   <= 5'd0;
			cycle_target  <= NORMAL_CONV_CYCLES;
			first_pending <= 1'b1;
		end else begin
			if (!enable_now) begin
				state         <= ST_IDLE; // Abort [RULE9]
				first_pending <= 1'b1;
			end else if (start_req && (state != ST_CONV || finish)) begin
				state         <= ST_CONV; // [RULE10]
				cycle_count   <= 5'd0;
				cycle_target  <= first_pending ? FIRST_CONV_CYCLES : NORMAL_CONV_CYCLES; // [RULE12]
				first_pending <= 1'b0;
			end else if (finish) begin
				state <= ST_DONE;
			end else if (converting && conv_tick) begin
				cycle_count <= cycle_count + 5'd1;
			end else if (state == ST_DONE) begin
				state <= ST_IDLE;
			end
		end
	end

	// Result capture, frozen between low and high byte reads
	always_ff @(posedge mclk) begin
		if (rst) begin
			result        <= 10'h000;
			result_locked <= 1'b0;
		end else begin
			if (finish && !result_locked)
				result <= coded; // [RULE1] [RULE2] [RULE3]
			if (bus_req.rd && bus_req.addr == OFF_RESULT_LOW)
				result_locked <= 1'b1; // [RULE16]
			else if (bus_req.rd && bus_req.addr == OFF_RESULT_HIGH)
				result_locked <= 1'b0; // [RULE16]
		end
	end

	// Done flag: completion wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst)
			conv_done_flag <= 1'b0;
		else if (finish)
			conv_done_flag <= 1'b1; // [RULE14]
		else if (irq_ack || (wr_ctrl && bus_req.wdata[BIT_DONE_FLAG]))
			conv_done_flag <= 1'b0; // [RULE14]
	end

	// Sticky status and mask for the shared interrupt line
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_status <= 8'h00;
			irq_mask   <= IRQ_MASK_RESET;
		end else begin
			if (bus_req.wr && bus_req.addr == OFF_IRQ_MASK)
				irq_mask <= bus_req.wdata;
			if (finish)
				irq_status[IRQ_BIT_DONE] <= 1'b1;
			else if (bus_req.wr && bus_req.addr == OFF_IRQ_STATUS && bus_req.wdata[IRQ_BIT_DONE])
				irq_status[IRQ_BIT_DONE] <= 1'b0;
		end
	end

	always_comb begin
		if (mux_sel[BIT_LEFT_ALIGN]) begin
			result_high_byte = result[9:2]; // [RULE6] [RULE17]
			result_low_byte  = {result[1:0], 6'h00};
		end else begin
			result_high_byte = {6'h00, result[9:8]}; // [RULE17]
			result_low_byte  = result[7:0];
		end
	end

	// Registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata           <= 8'h00;
			irq             <= 1'b0;
			done_irq_req    <= 1'b0;
			converter_power <= 1'b0;
			route           <= '0;
		end else begin
			irq             <= |(irq_status & irq_mask);
			done_irq_req    <= conv_done_flag && ctrl_a[BIT_DONE_IE]; // [RULE18]
			converter_power <= ctrl_a[BIT_ENABLE]; // [RULE9]
			route           <= next_route;
			rdata           <= 8'h00;
			if (bus_req.rd) begin
				case (bus_req.addr)
					OFF_RESULT_LOW:  rdata <= result_low_byte;
					OFF_RESULT_HIGH: rdata <= result_high_byte;
					OFF_CTRL_A:      rdata <= {ctrl_a[7:5], conv_done_flag, ctrl_a[3:0]};
					OFF_MUX_SEL:     rdata <= mux_sel;
					OFF_IRQ_STATUS:  rdata <= irq_status;
					OFF_IRQ_MASK:    rdata <= irq_mask;
					default:         rdata <= 8'h00;
				endcase
			end
		end
	end

	a_done_sets_flag: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
		finish |=> conv_done_flag) else $error("done flag not set after finish");
	a_start_reads_busy: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
		(state == ST_CONV && $past(state) == ST_CONV) |-> ctrl_a[BIT_START]) else $error("start bit low while busy");
	a_abort_on_off: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
		!enable_now |=> state == ST_IDLE) else $error("conversion not aborted");
	a_irq_req_level: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
		(conv_done_flag && ctrl_a[BIT_DONE_IE]) |=> done_irq_req) else $error("irq request missing");
	a_setting_hold: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
		(converting && $past(converting) && !$past(finish)) |-> $stable(active))
		else $error("setting changed mid conversion");
	a_lock_holds: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		result_locked |=> $stable(result)) else $error("result changed while locked");
	a_first_len: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
		(start_req && first_pending && enable_now && state != ST_CONV) |=> cycle_target == FIRST_CONV_CYCLES)
		else $error("first conversion length wrong");
	a_align_left: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
		(bus_req.rd && bus_req.addr == OFF_RESULT_HIGH && mux_sel[BIT_LEFT_ALIGN]) |=> rdata == $past(result[9:2]))
		else $error("left alignment wrong");
	a_align_right: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
		(bus_req.rd && bus_req.addr == OFF_RESULT_HIGH && !mux_sel[BIT_LEFT_ALIGN]) |=> rdata == {6'h00, $past(result[9:8])})
		else $error("right alignment wrong");
	a_done_clear_ack: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
		(irq_ack && !finish) |=> !conv_done_flag)
		else $error("done flag not cleared by acknowledge");
	a_done_clear_write: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
		(wr_ctrl && bus_req.wdata[BIT_DONE_FLAG] && !finish) |=> !conv_done_flag)
		else $error("done flag not cleared by write");
	a_busy_clears: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
		(finish && !start_req) |=> !ctrl_a[BIT_START])
		else $error("start bit high after completion");
	a_idle_not_busy: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
		(state != ST_CONV && !start_req) |=> !ctrl_a[BIT_START])
		else $error("start bit high without a start");
	a_power_on: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
		ctrl_a[BIT_ENABLE] |=> converter_power)
		else $error("converter not powered");
	a_power_off: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
		!ctrl_a[BIT_ENABLE] |=> !converter_power)
		else $error("converter powered while disabled");
	a_lock_on_low: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		(bus_req.rd && bus_req.addr == OFF_RESULT_LOW) |=> result_locked)
		else $error("low byte read did not lock");
	a_unlock_on_high: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		(bus_req.rd && bus_req.addr == OFF_RESULT_HIGH) |=> !result_locked)
		else $error("high byte read did not unlock");
	a_result_update: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
		(finish && !result_locked) |=> result == $past(coded))
		else $error("result not captured on completion");
	a_normal_len: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
		(start_req && !first_pending && enable_now && (state != ST_CONV || finish)) |=> cycle_target == NORMAL_CONV_CYCLES)
		else $error("normal conversion length wrong");
	a_free_restart: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
		(finish && ctrl_a[BIT_AUTO_TRIG] && enable_now) |=> state == ST_CONV)
		else $error("free running did not restart");
	a_single_stop: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
		(finish && !start_req && enable_now) |=> state == ST_DONE)
		else $error("single conversion did not stop");
	a_trigger_start: assert property (@(posedge mclk) disable iff (rst) // [RULE19]
		(enable_now && ctrl_a[BIT_AUTO_TRIG] && trigger_in && !trig_prev && state != ST_CONV) |=> state == ST_CONV)
		else $error("trigger edge did not start");
	a_reserved_ref: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
		(active.ref_sel == REF_RESERVED) |=> (!route.channel_valid && !route.ext_ref_on && !route.supply_ref_on && !route.internal_ref_on))
		else $error("reserved reference routed");
	a_tick_idle: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
		!converting |=> !conv_tick)
		else $error("conversion clock ticks while idle");
endmodule

/* File: hdl/adc_ctrl_pkg.sv */
// Package: register map, field positions, reset values and timing counts for the converter control block
package adc_ctrl_pkg;
	localparam logic [7:0] OFF_RESULT_LOW  = 8'h78;
	localparam logic [7:0] OFF_RESULT_HIGH = 8'h79;
	localparam logic [7:0] OFF_CTRL_A      = 8'h7A;
	localparam logic [7:0] OFF_MUX_SEL     = 8'h7C;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h70;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h71;
	localparam logic [7:0] CTRL_A_RESET    = 8'h00;
	localparam logic [7:0] MUX_SEL_RESET   = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET  = 8'h00;
	localparam int BIT_ENABLE     = 7;
	localparam int BIT_START      = 6;
	localparam int BIT_AUTO_TRIG  = 5;
	localparam int BIT_DONE_FLAG  = 4;
	localparam int BIT_DONE_IE    = 3;
	localparam int BIT_LEFT_ALIGN = 5;
	localparam int IRQ_BIT_DONE   = 0;
	localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
	localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
	localparam logic [9:0] SE_MAX_CODE        = 10'h3FF;
	localparam logic [9:0] DIFF_POS_LIMIT     = 10'h1FF;
	localparam logic [9:0] DIFF_NEG_LIMIT     = 10'h200;
	localparam logic [4:0] CH_BANDGAP         = 5'h1E;
	localparam logic [4:0] CH_GROUND          = 5'h1F;
	localparam logic [1:0] REF_EXTERNAL       = 2'h0;
	localparam logic [1:0] REF_SUPPLY         = 2'h1;
	localparam logic [1:0] REF_RESERVED       = 2'h2;
	localparam logic [1:0] REF_INTERNAL       = 2'h3;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [4:0] channel;
	} conv_setting_t;

	typedef struct packed {
		logic       ext_ref_on;
		logic       supply_ref_on;
		logic       internal_ref_on;
		logic       use_bandgap;
		logic       use_ground;
		logic       differential;
		logic [2:0] pos_input;
		logic [2:0] neg_input;
		logic       channel_valid;
	} mux_route_t;
endpackage

/* File: hdl/adc_clock_divider.sv */
// Conversion clock tick generator driven by the prescaler select field
`timescale 1ns/100ps
module adc_clock_divider (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] clock_divider_select,
	output logic            conv_tick
);
	logic [6:0] div_count;
	logic [6:0] terminal;

	always_comb begin
		// Codes 0 and 1 both divide by two [RULE15]
		if (clock_divider_select == 3'h0)
			terminal = 7'h01;
		else
			terminal = 7'((8'h01 << clock_divider_select) - 8'h01);
	end

	// Counter held at zero while idle so each conversion starts phase aligned
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			div_count <= 7'h00;
			conv_tick <= 1'b0;
		end else if (div_count >= terminal) begin
			div_count <= 7'h00;
			conv_tick <= 1'b1; // [RULE15]
		end else begin
			div_count <= div_count + 7'h01;
			conv_tick <= 1'b0;
		end
	end
endmodule

/* File: hdl/adc_result_coder.sv */
// Converts a sample of the routed inputs into a 10-bit single-ended or differential code
`timescale 1ns/100ps
module adc_result_coder (
	input  wire logic                    differential,
	input  wire logic [9:0]              pos_sample,
	input  wire logic [9:0]              neg_sample,
	output logic      [9:0]              code
);
	import adc_ctrl_pkg::*;
	logic signed [10:0] diff;
	logic signed [10:0] halved;

	always_comb begin
		// Samples are fractions of the reference in 1/1024 steps
		diff   = $signed({1'b0, pos_sample}) - $signed({1'b0, neg_sample});
		halved = diff >>> 1; // 512 steps per reference [RULE3]
		if (!differential)
			code = pos_sample; // [RULE2]
		else if (halved > $signed({1'b0, DIFF_POS_LIMIT}))
			code = DIFF_POS_LIMIT; // [RULE3]
		else if (halved < -$signed(11'sd512))
			code = DIFF_NEG_LIMIT; // [RULE3]
		else
			code = halved[9:0];
	end
endmodule

/* File: testbench/analog_source_model.sv */
// Analog front-end model: fixed sample levels for every input and the bandgap
`timescale 1ns/100ps
module analog_source_model #(
	parameter logic [9:0] BANDGAP_LEVEL = 10'h1A4
) (
	output logic [9:0] analog_input_n [8],
	output logic [9:0] bandgap_voltage
);
	// Even levels keep halved differences exact, so no rounding choice is tested
	assign analog_input_n = '{10'h000, 10'h3FE, 10'h200, 10'h154, 10'h0AA, 10'h300, 10'h07E, 10'h1C0};
	assign bandgap_voltage = BANDGAP_LEVEL;
endmodule

/* File: testbench/adc_control_and_result_logic_tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_control_and_result_logic_tb_top;
	import adc_ctrl_pkg::*;
	typedef struct packed {
		logic [7:0] mux;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [2:0] refs;
		logic       diff;
	} row_t;
	logic       mclk = 1'b0;
	logic       rst;
	reg_req_t   bus_req;
	logic [7:0] rdata;
	logic [9:0] analog_input_n [8];
	logic [9:0] bandgap_voltage;
	logic       trigger_in;
	logic       irq_ack;
	logic       irq;
	logic       done_irq_req;
	logic       converter_power;
	mux_route_t route;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         cycles = 0;
	int         cnt;
	int         dv;
	logic [7:0] d;
	logic [7:0] rst_addr [6] = '{OFF_CTRL_A, OFF_MUX_SEL, OFF_IRQ_MASK, OFF_IRQ_STATUS, OFF_RESULT_LOW, OFF_RESULT_HIGH};
	// Refs column is {external, supply, internal}
	row_t       rows [12] = '{
		'{8'h03, 8'h01, 8'h54, 3'h4, 1'b0}, '{8'h41, 8'h03, 8'hFE, 3'h2, 1'b0},
		'{8'hC7, 8'h01, 8'hC0, 3'h1, 1'b0}, '{8'h1E, 8'h01, 8'hA4, 3'h4, 1'b0},
		'{8'h1F, 8'h00, 8'h00, 3'h4, 1'b0}, '{8'h10, 8'h02, 8'h01, 3'h4, 1'b1},
		'{8'h55, 8'h03, 8'h81, 3'h2, 1'b1}, '{8'hD9, 8'h00, 8'hFF, 3'h1, 1'b1},
		'{8'h3D, 8'h20, 8'h00, 3'h4, 1'b1}, '{8'h38, 8'hC0, 8'h00, 3'h4, 1'b1},
		'{8'h23, 8'h55, 8'h00, 3'h4, 1'b0}, '{8'h61, 8'hFF, 8'h80, 3'h2, 1'b0}};

	adc_control i_adc_control (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
		.analog_input_n(analog_input_n), .bandgap_voltage(bandgap_voltage), .trigger_in(trigger_in),
		.irq_ack(irq_ack), .irq(irq), .done_irq_req(done_irq_req), .converter_power(converter_power),
		.route(route));
	analog_source_model i_analog_source_model (.analog_input_n(analog_input_n), .bandgap_voltage(bandgap_voltage));

	always #5 mclk = ~mclk;

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Ceiling well above the longest prescaler sweep
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			error_cnt++;
			results();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Strobe dropped with a spare edge so back-to-back calls never double-assign
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req <= '0;
		@(posedge mclk);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req <= '0;
		#1;
		v = rdata;
		@(posedge mclk);
	endtask

	// Skips a stale request left from the previous conversion
	task automatic conv_wait;
		cnt = 0;
		do begin
			@(posedge mclk);
			#1;
			cnt++;
		end while (!(done_irq_req === 1'b1 && cnt > 2) && cnt < 4000);
		check("conv_timeout", 16'(cnt < 4000), 16'h0001);
		@(posedge mclk);
	endtask

	initial begin
		rst = 1'b1;
		bus_req = '0;
		trigger_in = 1'b0;
		irq_ack = 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		wr_reg(8'h55, 8'hFF);
		foreach (rows[i]) begin
			rd_reg(i < 6 ? rst_addr[i] : 8'h55, d);
			check("reset_or_unmapped", 16'(d), 16'h0000);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			wr_reg(OFF_MUX_SEL, rows[i].mux);
			wr_reg(OFF_CTRL_A, 8'hD8);
			conv_wait();
			rd_reg(OFF_RESULT_LOW, d);
			check("result_low", 16'(d), 16'(rows[i].lo));
			rd_reg(OFF_RESULT_HIGH, d);
			check("result_high", 16'(d), 16'(rows[i].hi));
			check("route_refs", 16'({route.ext_ref_on, route.supply_ref_on, route.internal_ref_on}),
				16'(rows[i].refs));
			check("route_diff", 16'(route.differential), 16'(rows[i].diff));
			check("route_source", 16'({route.use_bandgap, route.use_ground}),
				16'({rows[i].mux[4:0] == CH_BANDGAP, rows[i].mux[4:0] == CH_GROUND}));
			check("route_pos_neg", 16'({route.pos_input, route.neg_input}), 16'({rows[i].mux[4:1] == 4'hF ? 3'h0 :
				rows[i].mux[2:0], rows[i].diff ? {1'b0, rows[i].mux[3], !rows[i].mux[3]} : 3'h0}));
		end
		$display("test rows done");
		for (int k = 0; k < 8; k++) begin
			dv = (k < 2) ? 2 : (1 << k);
			wr_reg(OFF_CTRL_A, 8'h00);
			wr_reg(OFF_CTRL_A, 8'hD8 | 8'(k));
			conv_wait();
			check("first_len", 16'(cnt >= 25 * dv - 1 && cnt <= 25 * dv + 4), 16'h0001);
			wr_reg(OFF_CTRL_A, 8'hD8 | 8'(k));
			conv_wait();
			check("normal_len", 16'(cnt >= 13 * dv - 1 && cnt <= 13 * dv + 4), 16'h0001);
		end
		$display("test timing done");
		wr_reg(OFF_MUX_SEL, 8'h03);
		wr_reg(OFF_CTRL_A, 8'hD8);
		wr_reg(OFF_MUX_SEL, 8'h21);
		rd_reg(OFF_CTRL_A, d);
		check("start_busy", 16'(d[BIT_START]), 16'h0001);
		conv_wait();
		rd_reg(OFF_RESULT_HIGH, d);
		check("held_channel", 16'(d), 16'h0055);
		rd_reg(OFF_CTRL_A, d);
		check("done_state", 16'(d & 8'h50), 16'h0010);
		rd_reg(OFF_RESULT_LOW, d);
		wr_reg(OFF_CTRL_A, 8'hD8);
		conv_wait();
		rd_reg(OFF_RESULT_HIGH, d);
		check("locked_high", 16'(d), 16'h0055);
		wr_reg(OFF_CTRL_A, 8'hD8);
		conv_wait();
		rd_reg(OFF_RESULT_LOW, d);
		check("new_low", 16'(d), 16'h0080);
		rd_reg(OFF_RESULT_HIGH, d);
		check("new_high", 16'(d), 16'h00FF);
		wr_reg(OFF_CTRL_A, 8'h98);
		repeat (100) @(posedge mclk);
		check("one_shot", 16'(done_irq_req), 16'h0000);
		$display("test hold_lock done");
		wr_reg(OFF_CTRL_A, 8'hD8);
		conv_wait();
		irq_ack <= 1'b1;
		@(posedge mclk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge mclk);
		check("ack_req", 16'(done_irq_req), 16'h0000);
		rd_reg(OFF_CTRL_A, d);
		check("ack_flag", 16'(d[BIT_DONE_FLAG]), 16'h0000);
		rd_reg(OFF_IRQ_STATUS, d);
		check("irq_status", 16'(d), 16'h0001);
		check("irq_masked", 16'(irq), 16'h0000);
		wr_reg(OFF_IRQ_MASK, 8'h01);
		repeat (2) @(posedge mclk);
		check("irq_unmasked", 16'(irq), 16'h0001);
		wr_reg(OFF_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge mclk);
		check("irq_cleared", 16'(irq), 16'h0000);
		$display("test interrupt done");
		wr_reg(OFF_CTRL_A, 8'h00);
		wr_reg(OFF_CTRL_A, 8'hD8);
		@(posedge mclk);
		check("power_on", 16'(converter_power), 16'h0001);
		repeat (10) @(posedge mclk);
		wr_reg(OFF_CTRL_A, 8'h08);
		repeat (150) @(posedge mclk);
		check("abort_power", 16'(converter_power), 16'h0000);
		check("abort_req", 16'(done_irq_req), 16'h0000);
		rd_reg(OFF_CTRL_A, d);
		check("abort_ctrl", 16'(d), 16'h0008);
		wr_reg(OFF_CTRL_A, 8'hF8);
		conv_wait();
		wr_reg(OFF_CTRL_A, 8'hB8);
		conv_wait();
		check("free_run", 16'(cnt <= 13 * 2 + 6), 16'h0001);
		wr_reg(OFF_CTRL_A, 8'h10);
		wr_reg(OFF_CTRL_A, 8'h98);
		repeat (100) @(posedge mclk);
		check("zero_start", 16'(done_irq_req), 16'h0000);
		wr_reg(OFF_CTRL_A, 8'hB8);
		repeat (100) @(posedge mclk);
		check("no_trigger", 16'(done_irq_req), 16'h0000);
		trigger_in <= 1'b1;
		conv_wait();
		check("trigger_conv", 16'(cnt <= 25 * 2 + 6), 16'h0001);
		trigger_in <= 1'b0;
		wr_reg(OFF_CTRL_A, 8'h10);
		$display("test modes done");
		foreach (rows[i]) begin
			wr_reg(OFF_MUX_SEL, i % 3 == 0 ? 8'h83 : (i % 3 == 1 ? 8'h08 : 8'h0F));
			repeat (3) @(posedge mclk);
			check("route_invalid", 16'(route.channel_valid), 16'h0000);
		end
		wr_reg(OFF_CTRL_A, 8'h80);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_reg(OFF_MUX_SEL, d);
		check("rerst_mux", 16'(d), 16'(MUX_SEL_RESET));
		check("rerst_power", 16'(converter_power), 16'h0000);
		$display("test reserved_reset done");
		results();
	end
endmodule
